// ==== opcode_decoder_pkg.sv ====
package opcode_decoder_pkg;

  // oscillator periods in one instruction cycle
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] LAST_PHASE = 2'(OSC_PER_INSTR - 1);

  // register indices on the plain register port
  localparam logic [3:0] REG_INSTR = 4'h0;
  localparam logic [3:0] REG_OPERAND = 4'h1;
  localparam logic [3:0] REG_ACC = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_PAGE = 4'h4;
  localparam logic [3:0] REG_BANK = 4'h5;
  localparam logic [3:0] REG_PTR0 = 4'h6;
  localparam logic [3:0] REG_PTR1 = 4'h7;
  localparam logic [3:0] REG_DECODE = 4'h8;
  localparam logic [3:0] REG_TRANSFER = 4'h9;
  localparam logic [3:0] REG_CONTROL = 4'hA;

  // status field positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_POWERDOWN = 3;
  localparam int FLAG_TIMEOUT = 4;

  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h18;
  localparam logic [6:0] PAGE_RESET = 7'h00;
  localparam logic [4:0] BANK_RESET = 5'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;

  // file addresses that reach memory through a pointer
  localparam logic [5:0] INDIRECT_PORT_BASE = 6'h00;

  typedef enum logic [5:0] {
    OP_OTHER, OP_NOP, OP_DEC_SKIP, OP_INC_SKIP, OP_BIT_CLEAR, OP_BIT_SET,
    OP_SKIP_CLEAR, OP_SKIP_SET, OP_ADD_K, OP_AND_K, OP_OR_K, OP_XOR_K,
    OP_SUB_K, OP_LOAD_K, OP_BANK_K, OP_PAGE_K, OP_REL_JUMP, OP_JUMP_ACC,
    OP_CALL, OP_CALL_ACC, OP_GOTO, OP_INT_RETURN, OP_RET_K, OP_RETURN,
    OP_WDT_KICK, OP_SOFT_RESET, OP_STANDBY, OP_PIN_DIR, OP_PTR_ADD,
    OP_IND_LOAD, OP_IND_LOAD_K, OP_IND_STORE, OP_IND_STORE_K
  } op_type;

endpackage

// ==== opcode_decoder.sv ====
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module opcode_decoder (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wstrobe,
  input wire logic rstrobe,
  output logic [15:0] rdata,
  output logic busy,
  output logic [15:0] data_addr,
  output logic [7:0] data_wdata,
  output logic data_write,
  output logic pc_load,
  output logic stack_push,
  output logic stack_pop,
  output logic interrupts_on,
  output logic watchdog_restart,
  output logic soft_reset,
  output logic standby,
  output logic pin_dir_load,
  output logic [2:0] pin_dir_select
);
  import opcode_decoder_pkg::*;

  // all checks below sample on the system clock and sleep during reset
  default clocking chk_clk @(posedge clk_sys); endclocking
  default disable iff (reset);

  // priority decode of one instruction word
  function automatic op_type decode_op(input logic [13:0] w);
    casez (w)
      14'b00_1011_????_????: decode_op = OP_DEC_SKIP;
      14'b00_1111_????_????: decode_op = OP_INC_SKIP;
      14'b01_00??_????_????: decode_op = OP_BIT_CLEAR;
      14'b01_01??_????_????: decode_op = OP_BIT_SET;
      14'b01_10??_????_????: decode_op = OP_SKIP_CLEAR;
      14'b01_11??_????_????: decode_op = OP_SKIP_SET;
      14'b11_1110_????_????: decode_op = OP_ADD_K;
      14'b11_1001_????_????: decode_op = OP_AND_K;
      14'b11_1000_????_????: decode_op = OP_OR_K;
      14'b11_1010_????_????: decode_op = OP_XOR_K;
      14'b11_1100_????_????: decode_op = OP_SUB_K;
      14'b11_0000_????_????: decode_op = OP_LOAD_K;
      14'b00_0000_001?_????: decode_op = OP_BANK_K;
      14'b11_0001_1???_????: decode_op = OP_PAGE_K;
      14'b11_0001_0???_????: decode_op = OP_PTR_ADD;
      14'b11_001?_????_????: decode_op = OP_REL_JUMP;
      14'b00_0000_0000_1011: decode_op = OP_JUMP_ACC;
      14'b10_0???_????_????: decode_op = OP_CALL;
      14'b00_0000_0000_1010: decode_op = OP_CALL_ACC;
      14'b10_1???_????_????: decode_op = OP_GOTO;
      14'b00_0000_0000_1001: decode_op = OP_INT_RETURN;
      14'b11_0100_????_????: decode_op = OP_RET_K;
      14'b00_0000_0000_1000: decode_op = OP_RETURN;
      14'b00_0000_0110_0100: decode_op = OP_WDT_KICK;
      14'b00_0000_0000_0000: decode_op = OP_NOP;
      14'b00_0000_0000_0001: decode_op = OP_SOFT_RESET;
      14'b00_0000_0110_0011: decode_op = OP_STANDBY;
      14'b00_0000_0110_0???: decode_op = OP_PIN_DIR;
      14'b00_0000_0001_0???: decode_op = OP_IND_LOAD;
      14'b00_0000_0001_1???: decode_op = OP_IND_STORE;
      14'b11_1111_0???_????: decode_op = OP_IND_LOAD_K;
      14'b11_1111_1???_????: decode_op = OP_IND_STORE_K;
      default: decode_op = OP_OTHER;
    endcase
  endfunction

  // architectural state
  logic [13:0] instr;
  logic [7:0] operand;
  logic [7:0] acc;
  logic [4:0] flags;
  logic [6:0] page;
  logic [4:0] bank;
  logic [15:0] ptr [2];
  op_type cur_op;
  logic [1:0] cycle_total;
  logic skip_taken;
  logic dest_file;
  logic [4:0] affected;
  logic [15:0] transfer;
  logic [1:0] phase;
  logic [1:0] cycles_left;

  // instruction fields of the word being written
  wire [13:0] word = wdata[13:0];
  wire op_type dec_op = decode_op(word);
  wire [2:0] bit_idx = word[9:7];
  wire [6:0] f_addr = word[6:0];
  wire dest_bit = word[7];
  wire [7:0] k8 = word[7:0];
  wire [1:0] upd_mode = word[1:0];
  wire accept = wstrobe && (addr == REG_INSTR) && !busy;

  // operand-side results
  wire [7:0] dec_res = operand - 8'h01;
  wire [7:0] inc_res = operand + 8'h01;
  wire bit_val = operand[bit_idx];
  wire [7:0] bit_mask = 8'(8'h01 << bit_idx);
  wire [8:0] sub9 = {1'b0, k8} - {1'b0, acc};
  wire [4:0] subn = {1'b0, k8[3:0]} - {1'b0, acc[3:0]};
  wire [8:0] add9 = {1'b0, k8} + {1'b0, acc};
  wire [4:0] addn = {1'b0, k8[3:0]} + {1'b0, acc[3:0]};

  // op classes
  wire is_mode_ind = (dec_op == OP_IND_LOAD) || (dec_op == OP_IND_STORE);
  wire is_k_ind = (dec_op == OP_IND_LOAD_K) || (dec_op == OP_IND_STORE_K);
  wire uses_file = (dec_op == OP_DEC_SKIP) || (dec_op == OP_INC_SKIP) ||
    (dec_op == OP_BIT_CLEAR) || (dec_op == OP_BIT_SET) ||
    (dec_op == OP_SKIP_CLEAR) || (dec_op == OP_SKIP_SET);
  wire pc_op = (dec_op == OP_REL_JUMP) || (dec_op == OP_JUMP_ACC) ||
    (dec_op == OP_CALL) || (dec_op == OP_CALL_ACC) ||
    (dec_op == OP_GOTO) || (dec_op == OP_INT_RETURN) ||
    (dec_op == OP_RET_K) || (dec_op == OP_RETURN);

  // pointer arithmetic
  wire ptr_sel = uses_file ? f_addr[0] : (is_mode_ind ? word[2] : word[6]);
  wire [15:0] ptr_cur = ptr[ptr_sel];
  wire [15:0] sext6 = {{10{word[5]}}, word[5:0]};
  wire [15:0] ptr_offset = ptr_cur + sext6;
  wire [15:0] ptr_step = ptr_cur + (upd_mode[0] ? 16'hFFFF : 16'h0001);
  wire [15:0] mode_addr = upd_mode[1] ? ptr_cur : ptr_step;
  wire [15:0] eff_addr = is_mode_ind ? mode_addr : ptr_offset;

  // cycle count: base, nop cycle, indirect program-memory cycle
  wire file_ind = uses_file && (f_addr[6:1] == INDIRECT_PORT_BASE);
  wire extra = (file_ind && ptr_cur[15]) ||
    ((is_mode_ind || is_k_ind) && eff_addr[15]);
  wire skip = ((dec_op == OP_DEC_SKIP) && (dec_res == 8'h00)) ||
    ((dec_op == OP_INC_SKIP) && (inc_res == 8'h00)) ||
    ((dec_op == OP_SKIP_CLEAR) && !bit_val) ||
    ((dec_op == OP_SKIP_SET) && bit_val);
  wire [1:0] next_total = 2'b01 + {1'b0, pc_op || skip} +
    {1'b0, extra};

  // effects of the accepted instruction
  logic [7:0] next_acc;
  logic [4:0] next_flags;
  logic [4:0] next_affected;
  logic [15:0] next_transfer;
  logic [15:0] next_ptr;
  logic next_ptr_write;
  logic [7:0] next_wdata;
  logic next_data_write;
  logic [15:0] next_addr;
  always_comb
  begin
    next_acc = acc;
    next_flags = flags;
    next_affected = 5'h00;
    next_transfer = 16'h0000;
    next_ptr = ptr_cur;
    next_ptr_write = 1'b0;
    next_wdata = 8'h00;
    next_data_write = 1'b0;
    next_addr = {4'h0, bank, f_addr};
    unique case (dec_op)
      OP_DEC_SKIP, OP_INC_SKIP:
      begin
        next_wdata = (dec_op == OP_DEC_SKIP) ? dec_res : inc_res;
        next_data_write = dest_bit;
        if (!dest_bit)
          next_acc = next_wdata;
      end
      OP_BIT_CLEAR:
      begin
        next_wdata = operand & ~bit_mask;
        next_data_write = 1'b1;
      end
      OP_BIT_SET:
      begin
        next_wdata = operand | bit_mask;
        next_data_write = 1'b1;
      end
      OP_ADD_K, OP_SUB_K:
      begin
        next_acc = (dec_op == OP_ADD_K) ? add9[7:0] : sub9[7:0];
        next_flags[FLAG_CARRY] = (dec_op == OP_ADD_K) ? add9[8] : !sub9[8];
        next_flags[FLAG_DIGIT] = (dec_op == OP_ADD_K) ? addn[4] : !subn[4];
        next_flags[FLAG_ZERO] = (next_acc == 8'h00);
        next_affected = 5'h07;
      end
      OP_AND_K, OP_OR_K, OP_XOR_K:
      begin
        if (dec_op == OP_AND_K)
          next_acc = acc & k8;
        else if (dec_op == OP_OR_K)
          next_acc = acc | k8;
        else
          next_acc = acc ^ k8;
        next_flags[FLAG_ZERO] = (next_acc == 8'h00);
        next_affected = 5'h04;
      end
      OP_LOAD_K, OP_RET_K:
        next_acc = k8;
      OP_REL_JUMP:
        next_transfer = {{7{word[8]}}, word[8:0]};
      OP_JUMP_ACC:
        next_transfer = {8'h00, acc};
      OP_CALL, OP_GOTO:
        next_transfer = {1'b0, page[6:3], word[10:0]};
      OP_CALL_ACC:
        next_transfer = {1'b0, page, acc};
      OP_WDT_KICK:
      begin
        next_flags[FLAG_TIMEOUT] = 1'b1;
        next_flags[FLAG_POWERDOWN] = 1'b1;
        next_affected = 5'h18;
      end
      OP_STANDBY:
      begin
        next_flags[FLAG_TIMEOUT] = 1'b1;
        next_flags[FLAG_POWERDOWN] = 1'b0;
        next_affected = 5'h18;
      end
      OP_PIN_DIR:
        next_wdata = acc;
      OP_PTR_ADD:
      begin
        next_ptr = ptr_offset;
        next_ptr_write = 1'b1;
      end
      OP_IND_LOAD, OP_IND_LOAD_K:
      begin
        next_acc = operand;
        next_flags[FLAG_ZERO] = (operand == 8'h00);
        next_affected = 5'h04;
        next_addr = eff_addr;
        next_ptr = ptr_step;
        next_ptr_write = is_mode_ind;
      end
      OP_IND_STORE, OP_IND_STORE_K:
      begin
        next_wdata = acc;
        next_data_write = 1'b1;
        next_addr = eff_addr;
        next_ptr = ptr_step;
        next_ptr_write = is_mode_ind;
      end
      default:
        next_acc = acc;
    endcase
  end

  // instruction-cycle sequencer, one enable every four clocks
  wire cycle_end = busy && (phase == LAST_PHASE);
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      busy <= 1'b0;
      phase <= 2'b00;
      cycles_left <= 2'b00;
    end
    else if (accept)
    begin
      busy <= 1'b1;
      phase <= 2'b00;
      cycles_left <= next_total - 2'b01;
    end
    else if (busy)
    begin
      phase <= phase + 2'b01;
      if (cycle_end && cycles_left == 2'b00)
        busy <= 1'b0;
      else if (cycle_end)
        cycles_left <= cycles_left - 2'b01;
    end
  end

  // software-written state and accepted instruction results
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      instr <= 14'h0000;
      operand <= 8'h00;
      acc <= ACC_RESET;
      flags <= STATUS_RESET;
      page <= PAGE_RESET;
      bank <= BANK_RESET;
    end
    else if (accept)
    begin
      instr <= word;
      acc <= next_acc;
      flags <= next_flags;
      if (dec_op == OP_PAGE_K)
        page <= word[6:0];
      if (dec_op == OP_BANK_K)
        bank <= word[4:0];
    end
    else if (wstrobe)
    begin
      if (addr == REG_OPERAND)
        operand <= wdata[7:0];
      if (addr == REG_ACC)
        acc <= wdata[7:0];
      if (addr == REG_STATUS)
        flags <= wdata[4:0];
      if (addr == REG_PAGE)
        page <= wdata[6:0];
      if (addr == REG_BANK)
        bank <= wdata[4:0];
    end
  end

  // the two indirect pointers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ptr
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
          ptr[gi] <= PTR_RESET;
        else if (accept && next_ptr_write && (ptr_sel == 1'(gi)))
          ptr[gi] <= next_ptr;
        else if (wstrobe && !accept && (addr == 4'(REG_PTR0 + gi)))
          ptr[gi] <= wdata;
      end
    end
  endgenerate

  // decode record, one-cycle action pulses and the standby latch
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cur_op <= OP_NOP;
      cycle_total <= 2'b00;
      skip_taken <= 1'b0;
      dest_file <= 1'b0;
      affected <= 5'h00;
      transfer <= 16'h0000;
      data_addr <= 16'h0000;
      data_wdata <= 8'h00;
      data_write <= 1'b0;
      pc_load <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      interrupts_on <= 1'b0;
      watchdog_restart <= 1'b0;
      soft_reset <= 1'b0;
      pin_dir_load <= 1'b0;
      pin_dir_select <= 3'h0;
      standby <= 1'b0;
    end
    else
    begin
      data_write <= accept && next_data_write;
      pc_load <= accept && pc_op;
      stack_push <= accept && ((dec_op == OP_CALL) ||
        (dec_op == OP_CALL_ACC));
      stack_pop <= accept && ((dec_op == OP_RETURN) ||
        (dec_op == OP_INT_RETURN) || (dec_op == OP_RET_K));
      interrupts_on <= accept && (dec_op == OP_INT_RETURN);
      watchdog_restart <= accept && (dec_op == OP_WDT_KICK);
      soft_reset <= accept && (dec_op == OP_SOFT_RESET);
      pin_dir_load <= accept && (dec_op == OP_PIN_DIR);
      if (accept)
      begin
        cur_op <= dec_op;
        cycle_total <= next_total;
        skip_taken <= skip;
        dest_file <= next_data_write;
        affected <= next_affected;
        transfer <= next_transfer;
        data_addr <= next_addr;
        data_wdata <= next_wdata;
        pin_dir_select <= word[2:0];
        if (dec_op == OP_STANDBY)
          standby <= 1'b1;
      end
      else if (wstrobe && addr == REG_CONTROL)
        standby <= 1'b0;
    end
  end

  // read mux, data valid only in the cycle after the strobe
  logic [15:0] read_mux;
  always_comb
  begin
    unique case (addr)
      REG_INSTR: read_mux = {2'b00, instr};
      REG_OPERAND: read_mux = {8'h00, operand};
      REG_ACC: read_mux = {8'h00, acc};
      REG_STATUS: read_mux = {11'h000, flags};
      REG_PAGE: read_mux = {9'h000, page};
      REG_BANK: read_mux = {11'h000, bank};
      REG_PTR0: read_mux = ptr[0];
      REG_PTR1: read_mux = ptr[1];
      REG_DECODE: read_mux = {cur_op, cycle_total, skip_taken, dest_file,
        1'b0, affected};
      REG_TRANSFER: read_mux = transfer;
      REG_CONTROL: read_mux = {14'h0000, standby, busy};
      default: read_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rdata <= 16'h0000;
    else
      rdata <= rstrobe ? read_mux : 16'h0000;
  end

  // checks on the decoded behaviour
  AST_DEC_SKIP: assert property (
    accept && dec_op == OP_DEC_SKIP |=>
      skip_taken == ($past(operand) == 8'h01))
    else $error("decrement skip wrong");
  AST_INC_SKIP: assert property (
    accept && dec_op == OP_INC_SKIP |=>
      skip_taken == ($past(operand) == 8'hFF))
    else $error("increment skip wrong");
  AST_BIT_SKIP: assert property (
    accept && dec_op == OP_SKIP_SET |=>
      skip_taken == operand[instr[9:7]])
    else $error("bit set test skip wrong");
  AST_OR_K: assert property (
    accept && dec_op == OP_OR_K |=>
      acc == ($past(acc) | instr[7:0]) &&
      flags[FLAG_CARRY] == $past(flags[FLAG_CARRY]))
    else $error("or constant wrong");
  AST_XOR_K: assert property (
    accept && dec_op == OP_XOR_K |=>
      acc == ($past(acc) ^ instr[7:0]) && flags[FLAG_ZERO] == (acc == 8'h00))
    else $error("xor constant wrong");
  AST_SUB_K: assert property (
    accept && dec_op == OP_SUB_K |=>
      acc == 8'(instr[7:0] - $past(acc)) &&
      flags[FLAG_CARRY] == (instr[7:0] >= $past(acc)))
    else $error("constant minus accumulator wrong");
  AST_PAGE_K: assert property (
    accept && dec_op == OP_PAGE_K |=> page == instr[6:0] && $stable(flags))
    else $error("page latch load wrong");
  AST_BRANCH_TWO: assert property (
    accept && pc_op |=> busy [*8] ##1 !busy)
    else $error("branch not two instruction cycles");
  AST_ONE_CYCLE: assert property (
    accept && next_total == 2'b01 |=> busy [*4] ##1 !busy)
    else $error("single cycle not four clocks");
  AST_INDIRECT_EXTRA: assert property (
    accept && dec_op == OP_IND_LOAD_K && ptr_offset[15] |=>
      cycle_total == 2'b10)
    else $error("indirect extra cycle missing");
  AST_STANDBY: assert property (
    accept && dec_op == OP_STANDBY |=> standby && flags[FLAG_TIMEOUT] &&
      !flags[FLAG_POWERDOWN])
    else $error("standby entry wrong");
  AST_PIN_DIR: assert property (
    accept && dec_op == OP_PIN_DIR |=> pin_dir_load &&
      data_wdata == $past(acc) ##1 !pin_dir_load)
    else $error("pin direction load wrong");
endmodule

// ==== prog_mem.sv ====
`timescale 1ns/10ps
module prog_mem (
  input wire logic [2:0] index,
  output logic [13:0] word
);
  // control words handed to the bench one slot at a time
  always_comb
  begin
    case (index)
      3'h0: word = 14'h000B; // jump_by_accumulator
      3'h1: word = 14'h000A; // subroutine_via_accumulator
      3'h2: word = 14'h3455; // return_with_constant
      3'h3: word = 14'h0008; // return
      3'h4: word = 14'h0009; // interrupt_return
      3'h5: word = 14'h2123; // absolute call
      default: word = 14'h2923; // absolute jump
    endcase
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import opcode_decoder_pkg::*;
  logic clk_sys, reset, wstrobe, rstrobe, busy, data_write, pc_load;
  logic stack_push, stack_pop, interrupts_on, watchdog_restart;
  logic soft_reset, standby, pin_dir_load;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, data_addr;
  logic [7:0] data_wdata, pulse;
  logic [2:0] pin_dir_select, index;
  logic [13:0] word;
  logic [7:0] exp_pulse [7] = '{8'h80, 8'hC0, 8'hA0, 8'hA0, 8'hB0,
    8'hC0, 8'h80};
  int n_fail, checked;

  opcode_decoder dut (.clk_sys(clk_sys), .reset(reset), .addr(addr),
    .wdata(wdata), .wstrobe(wstrobe), .rstrobe(rstrobe), .rdata(rdata),
    .busy(busy), .data_addr(data_addr), .data_wdata(data_wdata),
    .data_write(data_write), .pc_load(pc_load), .stack_push(stack_push),
    .stack_pop(stack_pop), .interrupts_on(interrupts_on),
    .watchdog_restart(watchdog_restart), .soft_reset(soft_reset),
    .standby(standby), .pin_dir_load(pin_dir_load),
    .pin_dir_select(pin_dir_select));
  prog_mem pm (.index(index), .word(word));

  // free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wstrobe <= 1'b1;
    @(posedge clk_sys);
    wstrobe <= 1'b0;
  endtask

  // read data only stands in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rstrobe <= 1'b1;
    @(posedge clk_sys);
    rstrobe <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // issue one word, grab the pulses, measure how long busy stays up
  task exec(input logic [13:0] w, input int cyc);
    int n;
    wr(REG_INSTR, {2'b00, w});
    #1;
    pulse = {pc_load, stack_push, stack_pop, interrupts_on,
      watchdog_restart, soft_reset, pin_dir_load, data_write};
    n = 0;
    while (busy === 1'b1 && n < 64)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(16'(n), 16'(OSC_PER_INSTR * cyc));
  endtask

  task t_reset;
    rd(REG_STATUS, 16'h0018);
    @(posedge clk_sys);
    #1;
    chk(rdata, 16'h0000);
    rd(REG_ACC, 16'h0000);
    rd(4'hF, 16'h0000);
  endtask

  task t_literal;
    exec(14'h3000, 1);
    exec(14'h3C03, 1);
    rd(REG_STATUS, 16'h001B);
    exec(14'h3830, 1);
    rd(REG_ACC, 16'h0033);
    rd(REG_STATUS, 16'h001B);
    exec(14'h3A33, 1);
    rd(REG_STATUS, 16'h001F);
    exec(14'h3005, 1);
    exec(14'h3C03, 1);
    rd(REG_ACC, 16'h00FE);
    rd(REG_STATUS, 16'h0018);
  endtask

  task t_skip;
    wr(REG_OPERAND, 16'h0001);
    exec(14'h0B20, 2);
    rd(REG_ACC, 16'h0000);
    wr(REG_OPERAND, 16'h0005);
    exec(14'h0B20, 1);
    rd(REG_ACC, 16'h0004);
    wr(REG_OPERAND, 16'h00FF);
    exec(14'h0FFF, 2);
    chk({8'h00, pulse}, 16'h0001);
    chk({8'h00, data_wdata}, 16'h0000);
    chk(data_addr, 16'h007F);
    wr(REG_OPERAND, 16'h0080);
    exec(14'h1FA0, 2);
    exec(14'h1BA0, 1);
    exec(14'h1820, 2);
    exec(14'h15A0, 1);
    chk({8'h00, data_wdata}, 16'h0088);
    exec(14'h13A0, 1);
    chk({8'h00, data_wdata}, 16'h0000);
  endtask

  task t_control;
    for (int i = 0; i < 7; i++)
    begin
      index = 3'(i);
      #1;
      exec(word, 2);
      chk({8'h00, pulse}, {8'h00, exp_pulse[i]});
    end
    rd(REG_ACC, 16'h0055);
  endtask

  task t_inherent;
    exec(14'h31AA, 1);
    rd(REG_PAGE, 16'h002A);
    rd(REG_STATUS, 16'h0018);
    exec(14'h0062, 1);
    chk({8'h00, pulse}, 16'h0002);
    chk({5'h00, pin_dir_select, data_wdata}, 16'h0255);
    exec(14'h0063, 1);
    chk({15'h0000, standby}, 16'h0001);
    rd(REG_STATUS, 16'h0010);
    rd(REG_CONTROL, 16'h0002);
    wr(REG_CONTROL, 16'h0000);
    rd(REG_CONTROL, 16'h0000);
    exec(14'h0064, 1);
    chk({8'h00, pulse}, 16'h0008);
    rd(REG_STATUS, 16'h0018);
    exec(14'h0001, 1);
    chk({8'h00, pulse}, 16'h0004);
  endtask

  task t_indirect;
    wr(REG_PTR0, 16'h0000);
    wr(REG_PTR1, 16'h8000);
    wr(REG_OPERAND, 16'h0000);
    exec(14'h0016, 2);
    chk(data_addr, 16'h8000);
    rd(REG_PTR1, 16'h8001);
    rd(REG_STATUS, 16'h001C);
    exec(14'h0018, 1);
    chk(data_addr, 16'h0001);
    chk({8'h00, pulse}, 16'h0001);
    exec(14'h313F, 1);
    rd(REG_PTR0, 16'h0000);
    exec(14'h3FC2, 2);
    chk(data_addr, 16'h8003);
    exec(14'h3F42, 2);
    chk(data_addr, 16'h8003);
    wr(REG_OPERAND, 16'h0007);
    exec(14'h3F05, 1);
    chk(data_addr, 16'h0005);
    rd(REG_ACC, 16'h0007);
    exec(14'h0B01, 2);
  endtask

  // a second word while busy must be dropped
  task t_refuse;
    wr(REG_INSTR, 16'h3011);
    wr(REG_INSTR, 16'h3077);
    repeat (6) @(posedge clk_sys);
    rd(REG_ACC, 16'h0011);
  endtask

  // literal add/and, bank, relative jump, paged call, decrement modes
  task t_decode;
    exec(14'h390F, 1);
    rd(REG_ACC, 16'h0001);
    exec(14'h3EFF, 1);
    rd(REG_STATUS, 16'h001F);
    rd(REG_DECODE, {6'(OP_ADD_K), 2'h1, 3'h0, 5'h07});
    exec(14'h0025, 1);
    rd(REG_BANK, 16'h0005);
    exec(14'h1420, 1);
    chk(data_addr, 16'h02A0);
    chk({8'h00, data_wdata}, 16'h0007);
    exec(14'h3380, 2);
    chk({8'h00, pulse}, 16'h0080);
    rd(REG_TRANSFER, 16'hFF80);
    rd(REG_DECODE, {6'(OP_REL_JUMP), 2'h2, 8'h00});
    wr(REG_PAGE, 16'h0041);
    exec(14'h2123, 2);
    rd(REG_TRANSFER, 16'h4123);
    exec(14'h0015, 2);
    chk(data_addr, 16'h8000);
    exec(14'h001F, 2);
    chk(data_addr, 16'h8000);
    rd(REG_PTR1, 16'h7FFF);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // cut a hang short well past the expected run length
  initial
  begin
    #500000;
    n_fail++;
    end_sim;
  end

  // reset, then the scenarios in turn
  initial
  begin
    reset = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wstrobe = 1'b0;
    rstrobe = 1'b0;
    index = 3'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_literal;
    t_skip;
    t_control;
    t_inherent;
    t_indirect;
    t_refuse;
    t_decode;
    end_sim;
  end
endmodule
